// [hdl/qed_pkg.sv]
// Package for the quadrature edge decoder: register map, fields, reset values
package qed_pkg;

    // ==================================================
    // Register map (byte addresses)
    localparam logic [7:0] MASK_LOW_ADDR = 8'h00;
    localparam logic [7:0] MASK_HIGH_ADDR = 8'h04;
    localparam logic [7:0] POSITION_ADDR = 8'h08;
    localparam logic [7:0] STATUS_ADDR = 8'h0c;
    localparam logic [7:0] TABLE_ADDR = 8'h10;

    // ==================================================
    // Field positions
    localparam int PHASE_A_MASK_BIT = 7;
    localparam int PHASE_B_MASK_BIT = 0;
    localparam int KEY_MASK_BIT = 2;
    localparam int CONV_MASK_BIT = 1;
    localparam logic [7:0] MASK_HIGH_FIXED = 8'hf8;
    localparam logic [7:0] MASK_LOW_WRITABLE = 8'hff;
    localparam logic [7:0] MASK_HIGH_WRITABLE = 8'h07;

    // ==================================================
    // Reset values
    localparam logic [7:0] MASK_LOW_RESET = 8'hff;
    localparam logic [7:0] MASK_HIGH_RESET = 8'hff;

    // ==================================================
    // Dispatch table: byte offset = pair*4 + phaseB*2
    localparam int TABLE_ENTRIES = 8;
    localparam int TABLE_STEP = 2;
    localparam int PAIR_STRIDE = 4;
    localparam logic [TABLE_ENTRIES-1:0] TABLE_UP = 8'h96;

    // ==================================================
    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        QED_NONE,
        QED_UP,
        QED_DOWN
    } qed_event_t;

    typedef struct packed {
        logic phaseA;
        logic phaseB;
    } qed_phases_t;

    typedef struct packed {
        logic sel;
        logic [1:0] htrans;
        logic [31:0] haddr;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } qed_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } qed_ahb_rsp_t;

endpackage

// [hdl/qed_input_sync.sv]
// Three-stage input synchroniser with agreement filter for both phases
`timescale 1ns/1ns
`default_nettype none
module qed_input_sync
    import qed_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire qed_pkg::qed_phases_t pinIn,
    output qed_pkg::qed_phases_t phaseOut
);
    import qed_pkg::*;

    logic [1:0] s1_r, s1_nxt;
    logic [1:0] s2_r, s2_nxt;
    logic [1:0] s3_r, s3_nxt;
    logic [1:0] out_r, out_nxt;

    // ==================================================
    // Per-phase stages; change accepted when stages two and three agree
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : gPhase
            always_comb begin
                s1_nxt[i] = (i == 0) ? pinIn.phaseB : pinIn.phaseA;
                s2_nxt[i] = s1_r[i];
                s3_nxt[i] = s2_r[i];
                out_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : out_r[i];
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s1_r <= 2'h0;
            s2_r <= 2'h0;
            s3_r <= 2'h0;
            out_r <= 2'h0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            out_r <= out_nxt;
        end
    end

    assign phaseOut.phaseA = out_r[1];
    assign phaseOut.phaseB = out_r[0];
endmodule // qed_input_sync
`default_nettype wire

// [hdl/qed_decoder.sv]
// Quadrature edge decoder top: AHB-Lite registers, dispatch table and counter
// Operation
// - Low mask bit 7 blocks phase A events
// - High mask bit 0 blocks phase B events
// - High mask 7..3 fixed one; key, converter masks
// - Both low: A rise down, B rise up
// - A high B low: A fall up, B rise down
// - A low B high: A rise up, B fall down
// - Both high: A fall down, B fall up
// - Table index: pair times four, B adds two
`timescale 1ns/1ns
`default_nettype none
module qed_decoder
    import qed_pkg::*;
#(
    parameter int POS_WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic phaseAPin,
    input wire logic phaseBPin,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic increment_handler,
    output logic decrement_handler,
    output logic [POS_WIDTH-1:0] position
);
    import qed_pkg::*;

    qed_phases_t pins;
    qed_phases_t phases;
    assign pins.phaseA = phaseAPin;
    assign pins.phaseB = phaseBPin;

    qed_input_sync uSync (
        .clk(clk),
        .rst_b(rst_b),
        .pinIn(pins),
        .phaseOut(phases)
    );

    // ==================================================
    // Registers
    logic [7:0] maskLow_r, maskLow_nxt;
    logic [7:0] maskHigh_r, maskHigh_nxt;
    logic [POS_WIDTH-1:0] pos_r, pos_nxt;
    qed_phases_t pair_r, pair_nxt;
    logic up_r, up_nxt;
    logic down_r, down_nxt;
    logic [3:0] tableIdx_r, tableIdx_nxt;
    logic [7:0] lastAddr_r, lastAddr_nxt;
    logic wrPend_r, wrPend_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    // ==================================================
    // Edge classification
    logic edgeA;
    logic edgeB;
    logic serviceA;
    logic serviceB;
    logic [3:0] offset;
    logic [2:0] entry;
    qed_event_t evt;

    always_comb begin
        edgeA = phases.phaseA != pair_r.phaseA;
        edgeB = phases.phaseB != pair_r.phaseB;
        serviceA = edgeA && !maskLow_r[PHASE_A_MASK_BIT];
        serviceB = edgeB && !maskHigh_r[PHASE_B_MASK_BIT];
        offset = 4'({pair_r.phaseB, pair_r.phaseA}) * 4'(PAIR_STRIDE);
        if (serviceB && !serviceA) begin
            offset = offset + 4'(TABLE_STEP);
        end
        entry = offset[3:1];
        evt = QED_NONE;
        if (serviceA || serviceB) begin
            // Entries
            evt = TABLE_UP[entry] ? QED_UP : QED_DOWN;
        end
        // Simultaneous moves of both unmasked phases carry no direction
        if (serviceA && serviceB) begin
            evt = QED_NONE;
        end
    end

    // ==================================================
    // Counter and level pair
    always_comb begin
        pair_nxt = pair_r;
        if (serviceA) begin
            pair_nxt.phaseA = phases.phaseA;
        end
        if (serviceB) begin
            pair_nxt.phaseB = phases.phaseB;
        end
        // Masked phase still tracks its level so later edges classify right
        if (edgeA && !serviceA) begin
            pair_nxt.phaseA = phases.phaseA;
        end
        if (edgeB && !serviceB) begin
            pair_nxt.phaseB = phases.phaseB;
        end
        pos_nxt = pos_r;
        up_nxt = 1'b0;
        down_nxt = 1'b0;
        tableIdx_nxt = tableIdx_r;
        case (evt)
            QED_UP: begin
                pos_nxt = pos_r + POS_WIDTH'(1);
                up_nxt = 1'b1;
                tableIdx_nxt = offset;
            end
            QED_DOWN: begin
                pos_nxt = pos_r - POS_WIDTH'(1);
                down_nxt = 1'b1;
                tableIdx_nxt = offset;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pos_r <= '0;
            pair_r <= '0;
            up_r <= 1'b0;
            down_r <= 1'b0;
            tableIdx_r <= 4'h0;
        end else begin
            pos_r <= pos_nxt;
            pair_r <= pair_nxt;
            up_r <= up_nxt;
            down_r <= down_nxt;
            tableIdx_r <= tableIdx_nxt;
        end
    end

    // ==================================================
    // AHB-Lite slave, zero wait states
    logic addrValid;
    assign addrValid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

    // ==================================================
    // Bus phase tracking: a write lands in its data phase
    always_comb begin
        wrPend_nxt = addrValid && hwrite;
        lastAddr_nxt = addrValid ? haddr[7:0] : lastAddr_r;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lastAddr_r <= 8'h00;
            wrPend_r <= 1'b0;
        end else begin
            lastAddr_r <= lastAddr_nxt;
            wrPend_r <= wrPend_nxt;
        end
    end

    // ==================================================
    // Mask registers
    always_comb begin
        maskLow_nxt = maskLow_r;
        maskHigh_nxt = maskHigh_r;
        if (wrPend_r) begin
            case (lastAddr_r)
                MASK_LOW_ADDR: maskLow_nxt = hwdata[7:0] & MASK_LOW_WRITABLE;
                MASK_HIGH_ADDR: maskHigh_nxt = MASK_HIGH_FIXED | (hwdata[7:0] & MASK_HIGH_WRITABLE);
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            maskLow_r <= MASK_LOW_RESET;
            maskHigh_r <= MASK_HIGH_RESET;
        end else begin
            maskLow_r <= maskLow_nxt;
            maskHigh_r <= maskHigh_nxt;
        end
    end

    // ==================================================
    // Read data; masks forwarded so a read right after a write sees it
    always_comb begin
        rdata_nxt = rdata_r;
        if (addrValid && !hwrite) begin
            case (haddr[7:0])
                MASK_LOW_ADDR: rdata_nxt = {24'h0, maskLow_nxt};
                MASK_HIGH_ADDR: rdata_nxt = {24'h0, maskHigh_nxt};
                POSITION_ADDR: rdata_nxt = 32'(pos_r);
                STATUS_ADDR: rdata_nxt = {30'h0, pair_r.phaseA, pair_r.phaseB};
                TABLE_ADDR: rdata_nxt = {28'h0, tableIdx_r};
                default: rdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign hrdata = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign increment_handler = up_r;
    assign decrement_handler = down_r;
    assign position = pos_r;
endmodule // qed_decoder
`default_nettype wire

// [tb/qed_decoder_properties.sv]
// Checker for the decoder top ports
`timescale 1ns/1ns
`default_nettype none
module qed_decoder_properties
    import qed_pkg::*;
#(
    parameter int POS_WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic increment_handler,
    input wire logic decrement_handler,
    input wire logic [POS_WIDTH-1:0] position
);
    logic wrLo_r, wrHi_r, rdLo_r, rdHi_r, mskA_r, mskB_r;
    wire logic tk = hsel && hready && htrans[1];
    wire logic lo = haddr[7:0] == MASK_LOW_ADDR;
    wire logic hi = haddr[7:0] == MASK_HIGH_ADDR;
    // Shadow of both phase masks
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            {wrLo_r, wrHi_r, rdLo_r, rdHi_r, mskA_r, mskB_r} <= 6'h03;
        end else begin
            {wrLo_r, wrHi_r} <= {tk && hwrite && lo, tk && hwrite && hi};
            {rdLo_r, rdHi_r} <= {tk && !hwrite && lo, tk && !hwrite && hi};
            mskA_r <= wrLo_r ? hwdata[PHASE_A_MASK_BIT] : mskA_r;
            mskB_r <= wrHi_r ? hwdata[PHASE_B_MASK_BIT] : mskB_r;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_upOnce;
        increment_handler ##1 !increment_handler;
    endsequence
    property p_upPulse; increment_handler |-> s_upOnce; endproperty
    property p_upStep; increment_handler |-> position == $past(position) + 1'b1; endproperty
    property p_dnStep; decrement_handler |-> position == $past(position) - 1'b1; endproperty
    property p_hold; !increment_handler && !decrement_handler |-> $stable(position); endproperty
    property p_oneKind; !(increment_handler && decrement_handler); endproperty
    property p_masked; increment_handler || decrement_handler |-> !($past(mskA_r) && $past(mskB_r)); endproperty
    property p_fixedOnes; rdHi_r |-> hrdata[7:3] == 5'h1f; endproperty
    property p_maskARead; rdLo_r |-> hrdata[7] == mskA_r; endproperty
    a_upPulse: assert property (p_upPulse) else $error("up pulse long");
    a_upStep: assert property (p_upStep) else $error("up step");
    a_dnStep: assert property (p_dnStep) else $error("down step");
    a_hold: assert property (p_hold) else $error("position moved");
    a_oneKind: assert property (p_oneKind) else $error("both pulses");
    a_masked: assert property (p_masked) else $error("masked count");
    a_fixedOnes: assert property (p_fixedOnes) else $error("fixed bits");
    a_maskARead: assert property (p_maskARead) else $error("mask A read");
endmodule // qed_decoder_properties
bind qed_decoder qed_decoder_properties #(.POS_WIDTH(POS_WIDTH)) u_props (.clk(clk), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .increment_handler(increment_handler), .decrement_handler(decrement_handler), .position(position));
`default_nettype wire

// [tb/qed_encoder_model.sv]
// Two-phase encoder model stepped one gray state per request
`timescale 1ns/1ns
`default_nettype none
module qed_encoder_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic step,
    input wire logic dirUp,
    output logic phaseA,
    output logic phaseB
);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            {phaseA, phaseB} <= 2'h0;
        end else if (step) begin
            // Up moves B on equal levels, A otherwise
            if ((phaseA == phaseB) == dirUp) phaseB <= !phaseB;
            else phaseA <= !phaseA;
        end
    end
endmodule // qed_encoder_model
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the quadrature edge decoder
`timescale 1ns/1ns
`default_nettype none
module tb;
    import qed_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, step = 1'b0, dirUp = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = HSIZE_WORD;
    logic hreadyout, hresp, increment_handler, decrement_handler, phaseA, phaseB;
    logic [15:0] position, expPos = 16'h0;
    int fail_count = 0, comparisons = 0, cycles = 0;
    initial forever #50 clk = !clk;
    qed_encoder_model enc (.clk(clk), .rst_b(rst_b), .step(step), .dirUp(dirUp), .phaseA(phaseA), .phaseB(phaseB));
    qed_decoder #(.POS_WIDTH(16)) dut (.clk(clk), .rst_b(rst_b), .phaseAPin(phaseA), .phaseBPin(phaseB),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .increment_handler(increment_handler),
        .decrement_handler(decrement_handler), .position(position));
    task automatic summarize();
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, HTRANS_NONSEQ, wr, 24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic move(input logic up, input logic [15:0] gain);
        int ups;
        int downs;
        ups = 0;
        downs = 0;
        @(posedge clk);
        {step, dirUp} <= {1'b1, up};
        @(posedge clk);
        step <= 1'b0;
        repeat (10) begin
            @(posedge clk);
            if (increment_handler !== 1'b0) ups++;
            if (decrement_handler !== 1'b0) downs++;
        end
        expPos = up ? expPos + gain : expPos - gain;
        chk("increment_handler", {31'h0, up && gain != 16'h0}, 32'(ups));
        chk("decrement_handler", {31'h0, !up && gain != 16'h0}, 32'(downs));
        rdchk("position", POSITION_ADDR, {16'h0, expPos});
    endtask
    // =====
    // Scenarios
    task automatic t_regs();
        rdchk("maskLow", MASK_LOW_ADDR, {24'h0, MASK_LOW_RESET});
        rdchk("maskHigh", MASK_HIGH_ADDR, {24'h0, MASK_HIGH_RESET});
        rdchk("unmapped", 8'h20, 32'h0);
        bus(1'b1, MASK_HIGH_ADDR, 32'h0);
        rdchk("maskHigh", MASK_HIGH_ADDR, {24'h0, MASK_HIGH_FIXED});
        bus(1'b1, MASK_HIGH_ADDR, 32'hffffff06);
        rdchk("maskHigh", MASK_HIGH_ADDR, 32'hfe);
        bus(1'b1, MASK_LOW_ADDR, 32'h5a);
        rdchk("maskLow", MASK_LOW_ADDR, 32'h5a);
    endtask
    task automatic t_masked();
        logic [7:0] lo [3] = '{8'hff, 8'hff, 8'h00};
        logic [7:0] hi [3] = '{8'hff, 8'hf8, 8'h01};
        logic [15:0] gain [6] = '{16'h0, 16'h0, 16'h1, 16'h0, 16'h0, 16'h1};
        for (int i = 0; i < 6; i++) begin
            if (i % 2 == 0) bus(1'b1, MASK_LOW_ADDR, {24'h0, lo[i/2]});
            if (i % 2 == 0) bus(1'b1, MASK_HIGH_ADDR, {24'h0, hi[i/2]});
            move(1'b1, gain[i]);
        end
    endtask
    task automatic t_walk();
        logic [3:0] offs [8] = '{4'he, 4'h4, 4'h2, 4'h8, 4'hc, 4'ha, 4'h0, 4'h6};
        logic [1:0] pr [8] = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h1, 2'h0, 2'h2, 2'h3};
        bus(1'b1, MASK_LOW_ADDR, 32'h0);
        bus(1'b1, MASK_HIGH_ADDR, 32'h0);
        for (int i = 0; i < 8; i++) begin
            move(i < 4, 16'h1);
            rdchk("offset", TABLE_ADDR, {28'h0, offs[i]});
            rdchk("status", STATUS_ADDR, {30'h0, pr[i]});
        end
    endtask
    task automatic t_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        expPos = 16'h0;
        rdchk("maskLow", MASK_LOW_ADDR, {24'h0, MASK_LOW_RESET});
        rdchk("maskHigh", MASK_HIGH_ADDR, {24'h0, MASK_HIGH_RESET});
        rdchk("position", POSITION_ADDR, 32'h0);
        rdchk("status", STATUS_ADDR, 32'h0);
        move(1'b1, 16'h0);
        rdchk("status", STATUS_ADDR, 32'h1);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_masked();
        t_walk();
        t_reset();
        summarize();
    end
endmodule // tb
`default_nettype wire
